// >>> rtl/dip_core.sv
// DMA front end: I/O decoder, idle/program/active modes and register access
module dip_core
    import dip_pkg::*;
(
    input wire logic mclk, // System clock, 100 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [dip_pkg::DIP_ADDR_W-1:0] io_addr, // CPU I/O address
    input wire logic [dip_pkg::DIP_DATA_W-1:0] io_wdata, // CPU write data
    input wire logic ior_n, // I/O read strobe
    input wire logic iow_n, // I/O write strobe
    input wire logic hlda, // Bus grant from CPU
    input wire logic [dip_pkg::DIP_XREQ_N-1:0] dreq, // Peripheral requests
    output dip_pkg::dip_sel_t io_sel, // Decoder enables
    output dip_pkg::dip_mode_t dma_mode, // Current mode
    output logic hold, // Bus request to CPU
    output logic xfer_go, // Transfer states begin
    output logic [dip_pkg::DIP_CHAN_W-1:0] xfer_chan, // Granted channel
    output logic rd_valid, // Read answer available
    input wire logic rd_ready, // Read answer taken
    output dip_pkg::dip_rdword_t rd_word // Read answer
);
    import dip_pkg::*;

    dip_core_t c;
    dip_core_t n;
    logic buf_ready;
    logic strobe;
    logic is_rd;
    logic dma_sel;
    logic pend_hlda;
    logic dis0;
    logic dis1;
    logic [DIP_CH_N-1:0] byte_pend;
    logic [DIP_CH_N-1:0] word_pend;
    logic any_req;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [DIP_PIN_N-1:0] filt(input logic [DIP_PIN_N-1:0] s1,
                                                 input logic [DIP_PIN_N-1:0] s2,
                                                 input logic [DIP_PIN_N-1:0] st);
        return (~(s1 ^ s2) & s2) | ((s1 ^ s2) & st);
    endfunction

    function automatic logic in_rng(input logic [DIP_ADDR_W-1:0] a,
                                    input logic [DIP_ADDR_W-1:0] lo,
                                    input logic [DIP_ADDR_W-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic dip_sel_t decode(input logic [DIP_ADDR_W-1:0] a);
        dip_sel_t s;
        s.byte_dma_unit = in_rng(a, DIP_BYTE_LO, DIP_BYTE_HI);
        s.pic1 = in_rng(a, DIP_PIC1_LO, DIP_PIC1_HI);
        s.cfg = in_rng(a, DIP_CFG_LO, DIP_CFG_HI);
        s.counter_timer_unit = in_rng(a, DIP_CTC_LO, DIP_CTC_HI);
        s.page = in_rng(a, DIP_PAGE_LO, DIP_PAGE_HI);
        s.pic2 = in_rng(a, DIP_PIC2_LO, DIP_PIC2_HI);
        s.word_dma_unit = in_rng(a, DIP_WORD_LO, DIP_WORD_HI);
        return s;
    endfunction

    function automatic logic [DIP_WORD_W-1:0] put_byte(input logic [DIP_WORD_W-1:0] w,
                                                      input logic hi,
                                                      input logic [DIP_DATA_W-1:0] d);
        return hi ? {d, w[DIP_DATA_W-1:0]} : {w[DIP_WORD_W-1:DIP_DATA_W], d};
    endfunction

    function automatic logic [DIP_DATA_W-1:0] get_byte(input logic [DIP_WORD_W-1:0] w,
                                                      input logic hi);
        return hi ? w[DIP_WORD_W-1:DIP_DATA_W] : w[DIP_DATA_W-1:0];
    endfunction

    function automatic logic [1:0] lowest(input logic [DIP_CH_N-1:0] r);
        logic [1:0] k;
        k = 2'h0;
        for (int i = DIP_CH_N - 1; i >= 0; i--) begin
            if (r[i]) begin
                k = 2'(i);
            end
        end
        return k;
    endfunction

    // Reset image: synchroniser and filter start at idle strobe levels, so no false access follows reset
    function automatic dip_core_t core_rst();
        dip_core_t r;
        r = DIP_CORE_RST;
        r.pin_st[DIP_PIN_IOR] = 1'b1;
        r.pin_st[DIP_PIN_IOW] = 1'b1;
        for (int i = 0; i < DIP_SYNC_N; i++) begin
            r.sync[i] = r.pin_st;
        end
        return r;
    endfunction

    localparam dip_core_t CORE_RST = core_rst();

    // ------------------------------------------------------------------
    // Request evaluation
    // ------------------------------------------------------------------
    assign strobe = ~c.pin_st[DIP_PIN_IOR] | ~c.pin_st[DIP_PIN_IOW];
    assign is_rd = ~c.pin_st[DIP_PIN_IOR];
    assign dma_sel = c.sel.byte_dma_unit | c.sel.word_dma_unit;
    assign pend_hlda = c.pin_st[DIP_PIN_HLDA];
    assign dis0 = c.cmd[0][DIP_CMD_DIS_BIT];
    assign dis1 = c.cmd[1][DIP_CMD_DIS_BIT];
    // Only programmed and unmasked channels count
    assign byte_pend = (c.pin_st[DIP_CH_N-1:0] | c.sreq[0]) & c.enab[0] & c.done[0] & {DIP_CH_N{~dis0}};
    // Byte unit feeds word channel zero, which needs no programming
    assign word_pend = ({c.pin_st[DIP_XREQ_N-1:DIP_CH_N], |byte_pend} | c.sreq[1]) & c.enab[1]
                       & (c.done[1] | DIP_CASCADE_MASK) & {DIP_CH_N{~dis1}};
    assign any_req = |word_pend;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic u;
        logic [DIP_IDX_W-1:0] idx;
        logic [1:0] ch;
        logic [DIP_DATA_W-1:0] rdv;
        logic [DIP_DATA_W-1:0] d;
        u = c.sel.word_dma_unit;
        idx = u ? c.addr[DIP_IDX_W:1] : c.addr[DIP_IDX_W-1:0];
        ch = idx[2:1];
        rdv = '0;
        d = io_wdata;
        n = c;
        n.xfer_go = 1'b0;
        // Pins pass three flops; a change counts once stages two and three agree
        n.sync[0] = {hlda, iow_n, ior_n, dreq};
        n.sync[1] = c.sync[0];
        n.sync[2] = c.sync[1];
        n.pin_st = filt(c.sync[1], c.sync[2], c.pin_st);
        n.addr = io_addr;
        n.sel = strobe ? decode(io_addr) : '0;
        if (c.rd_pend && buf_ready) begin
            n.rd_pend = 1'b0;
        end
        if (!dma_sel) begin
            n.acc_done = 1'b0;
        end

        // Mode selection, one mode at a time
        unique case (c.mode)
            DIP_IDLE: begin
                if (dma_sel && !pend_hlda) begin
                    n.mode = DIP_PROG;
                end else if (any_req) begin
                    n.mode = DIP_ACTIVE;
                    n.hold = 1'b1;
                end
            end
            DIP_PROG: begin
                if (!dma_sel) begin
                    n.mode = DIP_IDLE;
                end
            end
            DIP_ACTIVE: begin
                if (dma_sel && !pend_hlda && !c.granted) begin
                    n.mode = DIP_PROG;
                    n.hold = 1'b0;
                end else if (!any_req) begin
                    n.mode = DIP_IDLE;
                    n.hold = 1'b0;
                    n.granted = 1'b0;
                end else if (pend_hlda && c.hold && !c.granted) begin
                    n.granted = 1'b1;
                    n.xfer_go = 1'b1;
                    n.xfer_chan = word_pend[0] ? {1'b0, lowest(byte_pend)}
                                               : {1'b1, lowest(word_pend)};
                end
            end
        endcase

        // Register access, once per strobe, stalled by a full answer buffer
        if (c.mode == DIP_PROG && dma_sel && !c.acc_done && !c.rd_pend) begin
            n.acc_done = 1'b1;
            if (!idx[3]) begin
                if (is_rd) begin
                    rdv = get_byte(idx[0] ? c.cur_c[u][ch] : c.cur_a[u][ch], c.ptr[u]);
                end else if (idx[0]) begin
                    n.base_c[u][ch] = put_byte(c.base_c[u][ch], c.ptr[u], d);
                    n.cur_c[u][ch] = put_byte(c.cur_c[u][ch], c.ptr[u], d);
                    n.done[u][ch] = c.done[u][ch] | c.ptr[u];
                end else begin
                    n.base_a[u][ch] = put_byte(c.base_a[u][ch], c.ptr[u], d);
                    n.cur_a[u][ch] = put_byte(c.cur_a[u][ch], c.ptr[u], d);
                end
                n.ptr[u] = ~c.ptr[u];
            end else begin
                unique case (idx)
                    DIP_IDX_STAT: begin
                        if (is_rd) begin
                            rdv = {(u ? word_pend : byte_pend), {DIP_CH_N{1'b0}}};
                        end else begin
                            n.cmd[u] = d;
                        end
                    end
                    DIP_IDX_REQ: begin
                        if (is_rd) begin
                            rdv = {{DIP_CH_N{1'b0}}, c.sreq[u]};
                        end else begin
                            n.sreq[u][d[1:0]] = d[DIP_REQ_SET_BIT];
                        end
                    end
                    DIP_IDX_MASK1: begin
                        if (is_rd) begin
                            rdv = c.cmd[u];
                        end else begin
                            n.enab[u][d[1:0]] = ~d[DIP_MASK_SET_BIT];
                        end
                    end
                    DIP_IDX_MODE: begin
                        if (is_rd) begin
                            rdv = {c.chmode[u][c.mrc[u]], c.mrc[u]};
                            n.mrc[u] = DIP_MRC_W'(c.mrc[u] + 1'b1);
                        end else begin
                            n.chmode[u][d[1:0]] = d[DIP_DATA_W-1:2];
                        end
                    end
                    DIP_IDX_PTR: begin
                        n.ptr[u] = is_rd;
                    end
                    DIP_IDX_MCLR: begin
                        if (is_rd) begin
                            rdv = DIP_TEMP_RD;
                        end else begin
                            n.ptr[u] = 1'b0;
                            n.cmd[u] = '0;
                            n.sreq[u] = '0;
                            n.enab[u] = '0;
                            n.mrc[u] = '0;
                        end
                    end
                    DIP_IDX_CLRM: begin
                        if (is_rd) begin
                            n.mrc[u] = '0;
                        end else begin
                            n.enab[u] = '1;
                        end
                    end
                    DIP_IDX_MASKA: begin
                        if (is_rd) begin
                            rdv = {{DIP_CH_N{1'b0}}, ~c.enab[u]};
                        end else begin
                            n.enab[u] = ~d[DIP_CH_N-1:0];
                        end
                    end
                endcase
            end
            if (is_rd) begin
                n.rd_pend = 1'b1;
                n.rd_word = '{addr: c.addr, data: rdv};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            c <= CORE_RST;
        end else begin
            c <= n;
        end
    end

    // ------------------------------------------------------------------
    // Answer buffer and outputs
    // ------------------------------------------------------------------
    dip_buf #(
        .W($bits(dip_rdword_t)),
        .DEPTH(DIP_BUF_DEPTH)
    ) u_buf (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(c.rd_pend),
        .in_ready(buf_ready),
        .in_data(c.rd_word),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_word)
    );

    assign io_sel = c.sel;
    assign dma_mode = c.mode;
    assign hold = c.hold;
    assign xfer_go = c.xfer_go;
    assign xfer_chan = c.xfer_chan;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_BYTE_SEL: assert property (@(posedge mclk) disable iff (!nrst)
        io_sel.byte_dma_unit |-> $past(strobe) && $past(io_addr) <= DIP_BYTE_HI)
        else $error("byte unit select outside its range");
    AST_WORD_SEL: assert property (@(posedge mclk) disable iff (!nrst)
        $past(strobe) && $past(io_addr) >= DIP_WORD_LO && $past(io_addr) <= DIP_WORD_HI |-> io_sel.word_dma_unit)
        else $error("word unit select missing");
    AST_CTC_SEL: assert property (@(posedge mclk) disable iff (!nrst)
        io_sel.counter_timer_unit |-> $past(io_addr) >= DIP_CTC_LO && $past(io_addr) <= DIP_CTC_HI)
        else $error("timer enable outside its range");
    AST_NO_SEL: assert property (@(posedge mclk) disable iff (!nrst)
        $past(io_addr) > DIP_WORD_HI |-> io_sel == '0)
        else $error("enable for unmapped address");
    AST_IDLE_QUIET: assert property (@(posedge mclk) disable iff (!nrst)
        dma_mode == DIP_IDLE |-> !xfer_go && (!hold || $past(dma_mode) != DIP_IDLE))
        else $error("idle mode drives activity");
    AST_PROG_WINS: assert property (@(posedge mclk) disable iff (!nrst)
        dma_mode == DIP_IDLE && dma_sel && !pend_hlda && any_req |=> dma_mode == DIP_PROG && !hold)
        else $error("request beat register access");
    AST_PROG_EXIT: assert property (@(posedge mclk) disable iff (!nrst)
        dma_mode == DIP_PROG && !dma_sel |=> dma_mode == DIP_IDLE)
        else $error("program mode not left");
    AST_GO_AFTER_GRANT: assert property (@(posedge mclk) disable iff (!nrst)
        xfer_go |-> $past(hold) && $past(pend_hlda) && dma_mode == DIP_ACTIVE)
        else $error("transfer start without grant");
    AST_MCLR_PTR: assert property (@(posedge mclk) disable iff (!nrst)
        c.mode == DIP_PROG && dma_sel && !c.acc_done && !c.rd_pend && !is_rd
        && c.sel.byte_dma_unit && c.addr[DIP_IDX_W-1:0] == DIP_IDX_MCLR |=> c.ptr[0] == 1'b0)
        else $error("master clear left pointer set");
    AST_PTR_TOGGLE: assert property (@(posedge mclk) disable iff (!nrst)
        c.mode == DIP_PROG && c.sel.byte_dma_unit && !c.acc_done && !c.rd_pend && !c.addr[DIP_IDX_W-1]
        |=> c.ptr[0] != $past(c.ptr[0]))
        else $error("byte pointer did not advance");

    COV_PROG: cover property (@(posedge mclk) disable iff (!nrst)
        dma_mode == DIP_IDLE ##1 dma_mode == DIP_PROG ##[1:20] dma_mode == DIP_IDLE);
    COV_ACTIVE: cover property (@(posedge mclk) disable iff (!nrst) hold ##[1:20] xfer_go);
    COV_BUF_FULL: cover property (@(posedge mclk) disable iff (!nrst) c.rd_pend && !buf_ready);
endmodule

// >>> rtl/dip_pkg.sv
// Shared constants and types for the DMA idle/program front end
package dip_pkg;
    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int DIP_ADDR_W = 10;
    localparam int DIP_DATA_W = 8;
    localparam int DIP_CH_N = 4;
    localparam int DIP_WORD_W = 16;
    localparam int DIP_MODE_W = 6;
    localparam int DIP_MRC_W = 2;
    localparam int DIP_IDX_W = 4;
    localparam int DIP_CHAN_W = 3;
    localparam int DIP_XREQ_N = 7;
    localparam int DIP_PIN_N = 10;
    localparam int DIP_SYNC_N = 3;
    localparam int DIP_BUF_DEPTH = 2;

    // ------------------------------------------------------------------
    // Bit positions in the synchronised pin vector
    // ------------------------------------------------------------------
    localparam int DIP_PIN_IOR = 7;
    localparam int DIP_PIN_IOW = 8;
    localparam int DIP_PIN_HLDA = 9;

    // ------------------------------------------------------------------
    // Top level decoder ranges
    // ------------------------------------------------------------------
    localparam logic [DIP_ADDR_W-1:0] DIP_BYTE_LO = 10'h000;
    localparam logic [DIP_ADDR_W-1:0] DIP_BYTE_HI = 10'h00f;
    localparam logic [DIP_ADDR_W-1:0] DIP_PIC1_LO = 10'h020;
    localparam logic [DIP_ADDR_W-1:0] DIP_PIC1_HI = 10'h021;
    localparam logic [DIP_ADDR_W-1:0] DIP_CFG_LO = 10'h022;
    localparam logic [DIP_ADDR_W-1:0] DIP_CFG_HI = 10'h023;
    localparam logic [DIP_ADDR_W-1:0] DIP_CTC_LO = 10'h040;
    localparam logic [DIP_ADDR_W-1:0] DIP_CTC_HI = 10'h043;
    localparam logic [DIP_ADDR_W-1:0] DIP_PAGE_LO = 10'h080;
    localparam logic [DIP_ADDR_W-1:0] DIP_PAGE_HI = 10'h08f;
    localparam logic [DIP_ADDR_W-1:0] DIP_PIC2_LO = 10'h0a0;
    localparam logic [DIP_ADDR_W-1:0] DIP_PIC2_HI = 10'h0a1;
    localparam logic [DIP_ADDR_W-1:0] DIP_WORD_LO = 10'h0c0;
    localparam logic [DIP_ADDR_W-1:0] DIP_WORD_HI = 10'h0df;

    // ------------------------------------------------------------------
    // Register select indices inside one DMA unit
    // ------------------------------------------------------------------
    localparam logic [DIP_IDX_W-1:0] DIP_IDX_STAT = 4'h8;
    localparam logic [DIP_IDX_W-1:0] DIP_IDX_REQ = 4'h9;
    localparam logic [DIP_IDX_W-1:0] DIP_IDX_MASK1 = 4'ha;
    localparam logic [DIP_IDX_W-1:0] DIP_IDX_MODE = 4'hb;
    localparam logic [DIP_IDX_W-1:0] DIP_IDX_PTR = 4'hc;
    localparam logic [DIP_IDX_W-1:0] DIP_IDX_MCLR = 4'hd;
    localparam logic [DIP_IDX_W-1:0] DIP_IDX_CLRM = 4'he;
    localparam logic [DIP_IDX_W-1:0] DIP_IDX_MASKA = 4'hf;
    localparam int DIP_CMD_DIS_BIT = 2;
    localparam int DIP_MASK_SET_BIT = 2;
    localparam int DIP_REQ_SET_BIT = 2;
    localparam logic [DIP_CH_N-1:0] DIP_CASCADE_MASK = 4'h1;
    localparam logic [DIP_DATA_W-1:0] DIP_TEMP_RD = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {DIP_IDLE, DIP_PROG, DIP_ACTIVE} dip_mode_t;

    typedef struct packed {
        logic byte_dma_unit;
        logic pic1;
        logic cfg;
        logic counter_timer_unit;
        logic page;
        logic pic2;
        logic word_dma_unit;
    } dip_sel_t;

    typedef struct packed {
        logic [DIP_ADDR_W-1:0] addr;
        logic [DIP_DATA_W-1:0] data;
    } dip_rdword_t;

    typedef struct packed {
        dip_mode_t mode;
        logic [DIP_SYNC_N-1:0][DIP_PIN_N-1:0] sync;
        logic [DIP_PIN_N-1:0] pin_st;
        logic [DIP_ADDR_W-1:0] addr;
        dip_sel_t sel;
        logic acc_done;
        logic [1:0] ptr;
        logic [1:0][DIP_CH_N-1:0][DIP_WORD_W-1:0] base_a;
        logic [1:0][DIP_CH_N-1:0][DIP_WORD_W-1:0] cur_a;
        logic [1:0][DIP_CH_N-1:0][DIP_WORD_W-1:0] base_c;
        logic [1:0][DIP_CH_N-1:0][DIP_WORD_W-1:0] cur_c;
        logic [1:0][DIP_CH_N-1:0][DIP_MODE_W-1:0] chmode;
        logic [1:0][DIP_MRC_W-1:0] mrc;
        logic [1:0][DIP_DATA_W-1:0] cmd;
        logic [1:0][DIP_CH_N-1:0] enab;
        logic [1:0][DIP_CH_N-1:0] sreq;
        logic [1:0][DIP_CH_N-1:0] done;
        logic rd_pend;
        dip_rdword_t rd_word;
        logic hold;
        logic granted;
        logic xfer_go;
        logic [DIP_CHAN_W-1:0] xfer_chan;
    } dip_core_t;

    localparam dip_core_t DIP_CORE_RST = '0;
endpackage

// >>> rtl/dip_buf.sv
// Small valid/ready buffer holding read answers
module dip_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic mclk, // System clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [W-1:0] in_data, // Offered word
    output logic out_valid, // Word available
    input wire logic out_ready, // Receiver takes word
    output logic [W-1:0] out_data // Oldest word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } dip_buf_st_t;

    dip_buf_st_t c;
    dip_buf_st_t n;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == LAST) ? '0 : PW'(p + 1'b1);
    endfunction

    assign in_ready = (c.cnt != FULL);
    assign out_valid = (c.cnt != '0);
    assign out_data = c.mem[c.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        n = c;
        if (push) begin
            n.mem[c.wp] = in_data;
            n.wp = bump(c.wp);
        end
        if (pop) begin
            n.rp = bump(c.rp);
        end
        if (push && !pop) begin
            n.cnt = CW'(c.cnt + 1'b1);
        end else if (pop && !push) begin
            n.cnt = CW'(c.cnt - 1'b1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            c <= '0;
        end else begin
            c <= n;
        end
    end
endmodule

// >>> testbench/dip_cpu_mdl.sv
// Host model: grants the bus some cycles after a bus request
module dip_cpu_mdl (
    input wire logic mclk, // System clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic hold, // Bus request from the block
    input wire logic [3:0] lat, // Grant latency in cycles
    output logic hlda // Bus grant
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // Grant stands while the request stands, drops with it
    always_ff @(posedge mclk) begin
        if (!nrst || !hold) begin
            cnt <= 4'h0;
            hlda <= 1'b0;
        end else if (cnt >= lat) begin
            hlda <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// >>> testbench/dma_idle_program_control_tb_top.sv
// Self-checking bench for the DMA idle/program front end
module dma_idle_program_control_tb_top import dip_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, nrst = 1'b0, ior_n = 1'b1, iow_n = 1'b1, rd_ready = 1'b0;
    logic hold, xfer_go, rd_valid, hlda;
    logic [9:0] io_addr = 10'h000;
    logic [7:0] io_wdata = 8'h00;
    logic [6:0] dreq = 7'h00;
    logic [2:0] xfer_chan;
    logic [3:0] lat = 4'h1;
    dip_sel_t io_sel;
    dip_mode_t dma_mode;
    dip_rdword_t rd_word;
    int miscompares = 0, n_checks = 0, cyc = 0, k;
    logic [31:0] rs = 32'd24;
    logic [17:0] exp_q[$], msk_q[$];
    logic [9:0] sw[] = '{10'h000, 10'h00f, 10'h010, 10'h01f, 10'h020, 10'h021, 10'h022, 10'h023, 10'h024,
        10'h03f, 10'h040, 10'h043, 10'h044, 10'h07f, 10'h080, 10'h08f, 10'h090, 10'h0a0, 10'h0a1,
        10'h0a2, 10'h0bf, 10'h0c0, 10'h0df, 10'h0e0, 10'h3ff};
    dip_core dip_core_i (.mclk, .nrst, .io_addr, .io_wdata, .ior_n, .iow_n, .hlda, .dreq, .io_sel,
        .dma_mode, .hold, .xfer_go, .xfer_chan, .rd_valid, .rd_ready, .rd_word);
    dip_cpu_mdl dip_cpu_mdl_i (.mclk, .nrst, .hold, .lat, .hlda);
    initial begin
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] nxt(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic dip_sel_t sel_of(logic [9:0] a);
        return '{a <= 10'h00f, a inside {[10'h020:10'h021]}, a inside {[10'h022:10'h023]},
            a inside {[10'h040:10'h043]}, a inside {[10'h080:10'h08f]}, a inside {[10'h0a0:10'h0a1]},
            a inside {[10'h0c0:10'h0df]}};
    endfunction
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [17:0] e, logic [17:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One strobed access; reads of the DMA units queue their expected answer
    task automatic acc(logic wr, logic [9:0] a, logic [7:0] d, logic [17:0] m);
        logic dma;
        dip_sel_t sa;
        sa = sel_of(a);
        dma = sa.byte_dma_unit || sa.word_dma_unit;
        @(posedge mclk);
        #1 io_addr = a;
        io_wdata = d;
        if (wr) iow_n = 1'b0;
        else ior_n = 1'b0;
        if (!wr && dma) begin
            exp_q.push_back({a, d} & m);
            msk_q.push_back(m);
        end
        repeat (8) @(posedge mclk);
        #1 chk("io_sel", 18'(sel_of(a)), 18'(io_sel));
        if (dma) chk("dma_mode", 18'(DIP_PROG), 18'(dma_mode));
        iow_n = 1'b1;
        ior_n = 1'b1;
        repeat (8) @(posedge mclk);
    endtask
    // Pointer and address port checks; o=1 sets A0, which the word unit ignores
    task automatic prog(logic [9:0] b, int s, int o);
        logic [9:0] p;
        logic [7:0] lo, hi;
        p = 10'(b + 2 * s + o);
        rs = nxt(rs);
        lo = rs[7:0];
        hi = rs[15:8];
        acc(1'b1, 10'(b + 12 * s + o), 8'h00, '1);
        acc(1'b1, p, lo, '1);
        acc(1'b1, p, hi, '1);
        acc(1'b0, p, lo, '1);
        acc(1'b0, p, hi, '1);
        acc(1'b0, 10'(b + 12 * s + o), 8'h00, 18'h3ff00);
        acc(1'b0, p, hi, '1);
        acc(1'b1, 10'(b + 13 * s + o), 8'h00, '1);
        acc(1'b0, p, lo, '1);
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
        if (nrst && rd_valid === 1'b1 && rd_ready === 1'b1) begin
            if (exp_q.size() == 0) chk("rd_extra", 18'h0, 18'h1);
            else chk("rd_word", exp_q.pop_front(), rd_word & msk_q.pop_front());
        end
        #1 rs = nxt(rs);
        rd_ready = rs[0];
    end
    initial begin
        repeat (8) @(posedge mclk);
        #1 nrst = 1'b1;
        repeat (6) @(posedge mclk);
        foreach (sw[i]) acc(1'b0, sw[i], 8'h00, 18'h3ff00);
        repeat (4) acc(1'b0, 10'(nxt(rs)), 8'h00, 18'h3ff00);
        prog(10'h000, 1, 0);
        prog(10'h0c0, 2, 1);
        acc(1'b1, 10'h003, 8'h10, '1);
        acc(1'b1, 10'h003, 8'h00, '1);
        acc(1'b1, 10'h00e, 8'h00, '1);
        acc(1'b1, 10'h0dc, 8'h00, '1);
        for (int j = 0; j < 2; j++) begin
            #1 lat = j ? 4'h6 : 4'h0;
            dreq[1] = 1'b1;
            for (k = 0; k < 40 && xfer_go !== 1'b1; k++) begin
                @(posedge mclk);
                #1;
            end
            chk("xfer_go", 18'h1, 18'(xfer_go));
            chk("xfer_chan", 18'h1, 18'(xfer_chan));
            chk("active", 18'(DIP_ACTIVE), 18'(dma_mode));
            dreq[1] = 1'b0;
            repeat (20) @(posedge mclk);
            #1 chk("idle", 18'(DIP_IDLE), 18'(dma_mode));
        end
        // Request arrives one cycle after the strobe: register access must still win
        fork
            acc(1'b1, 10'h009, 8'h00, '1);
            begin
                repeat (2) @(posedge mclk);
                #1 dreq[1] = 1'b1;
            end
        join
        #1 dreq[1] = 1'b0;
        repeat (20) @(posedge mclk);
        #1 dreq[2] = 1'b1;
        repeat (12) @(posedge mclk);
        #1 chk("hold_unprog", 18'h0, 18'(hold));
        dreq[2] = 1'b0;
        repeat (20) @(posedge mclk);
        chk("rd_left", 18'h0, 18'(exp_q.size()));
        give_verdict();
    end
endmodule
